// ==== verilog/eaps_pkg.sv ====
// Constants shared by the address pin sharing logic.
// Assumes one system clock domain and a synchronous active-low reset.
package eaps_pkg;

  // ****************************************
  // Pin map
  // ****************************************
  localparam int PIN_CNT = 10;
  localparam int PORTE_LO = 2;
  localparam int PORTE_HI = 3;
  localparam int PORTE_CNT = 2;
  localparam int PORTA_W = 8;
  localparam int CTRL_W = 3;
  localparam int SYNC_STAGES = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic FUNC_ADDR = 1'b0;
  localparam logic FUNC_GPIO = 1'b1;
  localparam logic DRIVE_KEEP_RST = 1'b0;
  localparam logic [PORTE_HI:PORTE_LO] PORTE_PU_RST = 2'h3;
  localparam logic [PORTA_W-1:0] PORTA_PU_RST = 8'hFF;
  localparam logic [PORTE_HI:PORTE_LO] PORTE_SEL_RST = 2'h0;
  localparam logic [PORTA_W-1:0] PORTA_SEL_RST = 8'h00;

endpackage

// ==== verilog/eaps_pin_sync.sv ====
// Two-flop synchroniser for pin levels.
// Assumes its inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
module eaps_pin_sync #(
  parameter int W = 10
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
    if (!rstn) begin
      meta_nxt = '0;
      sync_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    meta_r <= meta_nxt;
    syncOut <= sync_nxt;
  end

endmodule

// ==== verilog/ext_address_pin_sharing.sv ====
// Pin-sharing logic for address lines A6-A15 and their GPIO alternates.
// Assumes the memory interface drives addrOut, ctrlOut and extBusActive
// on sys_clk; pin levels arrive asynchronously on pinIn.
`timescale 1ns/1ps
module ext_address_pin_sharing
  import eaps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  // Memory interface side
  input wire logic [PIN_CNT-1:0] addrOut,
  input wire logic [CTRL_W-1:0] ctrlOut,
  input wire logic extBusActive,
  // Bus control register, drive-keep field
  input wire logic busDriveKeepWr,
  input wire logic busDriveKeep,
  // Port E configuration
  input wire logic portESelWr,
  input wire logic [PORTE_HI:PORTE_LO] portESel,
  input wire logic portEPullupWr,
  input wire logic [PORTE_HI:PORTE_LO] portEPullup,
  input wire logic [PORTE_HI:PORTE_LO] portEDir,
  input wire logic [PORTE_HI:PORTE_LO] portEData,
  // Port A configuration
  input wire logic portASelWr,
  input wire logic [PORTA_W-1:0] portASel,
  input wire logic portAPullupWr,
  input wire logic [PORTA_W-1:0] portAPullup,
  input wire logic [PORTA_W-1:0] portADir,
  input wire logic [PORTA_W-1:0] portAData,
  // Pads, index 0 is A6, index 9 is A15
  input wire logic [PIN_CNT-1:0] pinIn,
  output logic [PIN_CNT-1:0] pinOut,
  output logic [PIN_CNT-1:0] pinOe,
  output logic [PIN_CNT-1:0] pinPullup,
  output logic [CTRL_W-1:0] ctrlPinOut,
  output logic [CTRL_W-1:0] ctrlPinOe,
  // Status
  output logic busDriveKeepSts,
  output logic [PORTE_HI:PORTE_LO] portEIn,
  output logic [PORTA_W-1:0] portAIn
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic driveKeep_r;
  logic driveKeep_nxt;
  logic [PORTE_HI:PORTE_LO] selE_r;
  logic [PORTE_HI:PORTE_LO] selE_nxt;
  logic [PORTA_W-1:0] selA_r;
  logic [PORTA_W-1:0] selA_nxt;
  logic [PORTE_HI:PORTE_LO] puE_r;
  logic [PORTE_HI:PORTE_LO] puE_nxt;
  logic [PORTA_W-1:0] puA_r;
  logic [PORTA_W-1:0] puA_nxt;

  always_comb begin
    driveKeep_nxt = driveKeep_r;
    selE_nxt = selE_r;
    selA_nxt = selA_r;
    puE_nxt = puE_r;
    puA_nxt = puA_r;
    if (!rstn) begin
      driveKeep_nxt = DRIVE_KEEP_RST;
      selE_nxt = PORTE_SEL_RST;
      selA_nxt = PORTA_SEL_RST;
      puE_nxt = PORTE_PU_RST;
      puA_nxt = PORTA_PU_RST;
    end else begin
      if (busDriveKeepWr) begin
        driveKeep_nxt = busDriveKeep;
      end
      if (portESelWr) begin
        selE_nxt = portESel;
      end
      if (portASelWr) begin
        selA_nxt = portASel;
      end
      if (portEPullupWr) begin
        puE_nxt = portEPullup;
      end
      if (portAPullupWr) begin
        puA_nxt = portAPullup;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    driveKeep_r <= driveKeep_nxt;
    selE_r <= selE_nxt;
    selA_r <= selA_nxt;
    puE_r <= puE_nxt;
    puA_r <= puA_nxt;
  end

  // ****************************************
  // Pin vectors in pad order
  // ****************************************
  logic [PIN_CNT-1:0] gpioSel;
  logic [PIN_CNT-1:0] gpioDir;
  logic [PIN_CNT-1:0] gpioData;
  logic [PIN_CNT-1:0] puEn;
  logic addrDrive;

  assign gpioSel = {selA_r, selE_r};
  assign gpioDir = {portADir, portEDir};
  assign gpioData = {portAData, portEData};
  assign puEn = {puA_r, puE_r};
  assign addrDrive = driveKeep_r | extBusActive;

  // ****************************************
  // Pad drivers
  // ****************************************
  logic [PIN_CNT-1:0] pinOut_nxt;
  logic [PIN_CNT-1:0] pinOe_nxt;
  logic [PIN_CNT-1:0] pinPullup_nxt;
  logic [CTRL_W-1:0] ctrlPinOut_nxt;
  logic [CTRL_W-1:0] ctrlPinOe_nxt;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_CNT; gi++) begin : g_pin
      always_comb begin
        if (!rstn) begin
          pinOut_nxt[gi] = 1'b0;
          pinOe_nxt[gi] = 1'b0;
          pinPullup_nxt[gi] = 1'b1;
        end else if (gpioSel[gi] == FUNC_GPIO) begin
          pinOut_nxt[gi] = gpioData[gi];
          pinOe_nxt[gi] = gpioDir[gi];
          pinPullup_nxt[gi] = puEn[gi] & ~gpioDir[gi];
        end else begin
          pinOut_nxt[gi] = addrOut[gi];
          pinOe_nxt[gi] = addrDrive;
          pinPullup_nxt[gi] = puEn[gi] & ~addrDrive;
        end
      end
    end
  endgenerate

  always_comb begin
    ctrlPinOut_nxt = ctrlOut;
    ctrlPinOe_nxt = {CTRL_W{addrDrive}};
    if (!rstn) begin
      ctrlPinOut_nxt = '0;
      ctrlPinOe_nxt = '0;
    end
  end

  always_ff @(posedge sys_clk) begin
    pinOut <= pinOut_nxt;
    pinOe <= pinOe_nxt;
    pinPullup <= pinPullup_nxt;
    ctrlPinOut <= ctrlPinOut_nxt;
    ctrlPinOe <= ctrlPinOe_nxt;
    busDriveKeepSts <= driveKeep_nxt;
  end

  // ****************************************
  // Pad inputs
  // ****************************************
  logic [PIN_CNT-1:0] pinSync;

  eaps_pin_sync #(
    .W(PIN_CNT)
  ) u_sync (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .asyncIn(pinIn),
    .syncOut(pinSync)
  );

  assign portEIn = pinSync[PORTE_CNT-1:0];
  assign portAIn = pinSync[PIN_CNT-1:PORTE_CNT];

  // ****************************************
  // Assertions
  // ****************************************
  sequence idle_seq;
    !driveKeep_r && !extBusActive;
  endsequence

  sequence keep_seq;
    driveKeep_r;
  endsequence

  reset_pads_a: assert property (@(posedge sys_clk)
    !rstn |=> (pinOe == '0) && (pinPullup == '1) && (ctrlPinOe == '0))
    else $error("pads not safe in reset");

  default_addr_a: assert property (@(posedge sys_clk)
    !rstn ##1 rstn && !portESelWr && !portASelWr |-> gpioSel == '0)
    else $error("pins not address after reset");

  idle_float_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    idle_seq ##0 (gpioSel == '0) |=> (pinOe == '0) && (ctrlPinOe == '0))
    else $error("address driven while bus idle");

  keep_drive_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    keep_seq ##1 rstn |-> (ctrlPinOe == '1)
      && ((pinOe & ~$past(gpioSel)) == ~$past(gpioSel)))
    else $error("drive keep ignored");

  porte_dir_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    selE_r[PORTE_LO] |=> pinOe[0] == $past(portEDir[PORTE_LO]))
    else $error("port E direction wrong");

  porta_dir_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    selA_r[0] |=> pinOe[PORTE_CNT] == $past(portADir[0]))
    else $error("port A direction wrong");

  porte_pull_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !puE_r[PORTE_LO] |=> !pinPullup[0])
    else $error("port E pull-up not off");

  porta_pull_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !puA_r[0] |=> !pinPullup[PORTE_CNT])
    else $error("port A pull-up not off");

  pull_write_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    portAPullupWr && !portAPullup[0] |=> ##1 !pinPullup[PORTE_CNT])
    else $error("port A pull-up write lost");

endmodule

// ==== sim/eaps_ext_mem.sv ====
// Pad model of the external memory on the shared address pins.
// Assumes the pad outputs of the pin sharing logic; feeds pinIn back.
`timescale 1ns/1ps
module eaps_ext_mem
  import eaps_pkg::*;
(
  input wire logic [PIN_CNT-1:0] pinOut,
  input wire logic [PIN_CNT-1:0] pinOe,
  input wire logic [PIN_CNT-1:0] pinPullup,
  input wire logic [PIN_CNT-1:0] extLevel,
  output logic [PIN_CNT-1:0] padLevel
);
  // Memory drives a line only when it is neither driven nor pulled up; a pull-up wins over its own level
  always_comb begin
    for (int i = 0; i < PIN_CNT; i++) begin
      if (pinOe[i]) begin
        padLevel[i] = pinOut[i];
      end else if (pinPullup[i]) begin
        padLevel[i] = 1'b1;
      end else begin
        padLevel[i] = extLevel[i];
      end
    end
  end
endmodule

// ==== sim/test_ext_address_pin_sharing.sv ====
// Self-checking bench for the address pin sharing logic.
// Assumes eaps_pkg and the design files are compiled first.
`timescale 1ns/1ps
module test_ext_address_pin_sharing;
  import eaps_pkg::*;
  logic sys_clk, rstn, extBusActive, busDriveKeepWr, busDriveKeep;
  logic portESelWr, portEPullupWr, portASelWr, portAPullupWr;
  logic [PIN_CNT-1:0] addrOut, pinIn, pinOut, pinOe, pinPullup, extLvl;
  logic [CTRL_W-1:0] ctrlOut, ctrlPinOut, ctrlPinOe;
  logic busDriveKeepSts;
  logic [PORTE_HI:PORTE_LO] portESel, portEPullup, portEDir, portEData;
  logic [PORTE_HI:PORTE_LO] portEIn;
  logic [PORTA_W-1:0] portASel, portAPullup, portADir, portAData, portAIn;
  int numErrors = 0;
  int nTests = 0;

  ext_address_pin_sharing u_ext_address_pin_sharing (.sys_clk, .rstn,
    .addrOut, .ctrlOut, .extBusActive, .busDriveKeepWr, .busDriveKeep,
    .portESelWr, .portESel, .portEPullupWr, .portEPullup, .portEDir,
    .portEData, .portASelWr, .portASel, .portAPullupWr, .portAPullup,
    .portADir, .portAData, .pinIn, .pinOut, .pinOe, .pinPullup,
    .ctrlPinOut, .ctrlPinOe, .busDriveKeepSts, .portEIn, .portAIn);
  eaps_ext_mem u_eaps_ext_mem (.pinOut, .pinOe, .pinPullup,
    .extLevel(extLvl), .padLevel(pinIn));

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  // ****************************************
  // Helpers
  // ****************************************
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task chk(input logic [9:0] seen, input logic [9:0] exp);
    nTests++;
    if (seen !== exp) begin
      numErrors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task testDone;
    $display("errors %0d, checks %0d", numErrors, nTests);
    if (numErrors == 0 && nTests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task tReset;
    step(3);
    chk(pinOe, 10'h000);
    chk(pinPullup, 10'h3FF);
    rstn = 1'b1;
    step(2);
    chk(pinOe, 10'h000);
    chk(pinOut, 10'h2A5);
    chk(10'(ctrlPinOe), 10'h000);
  endtask

  task tDrive;
    extBusActive = 1'b1;
    step(2);
    chk(pinOe, 10'h3FF);
    chk(pinOut, 10'h2A5);
    chk(10'(ctrlPinOut), 10'h005);
    extBusActive = 1'b0;
    busDriveKeep = 1'b1;
    busDriveKeepWr = 1'b1;
    step(1);
    busDriveKeepWr = 1'b0;
    chk(10'(busDriveKeepSts), 10'h001);
    chk(pinOe, 10'h000);
    chk(10'(ctrlPinOe), 10'h000);
    step(1);
    chk(pinOe, 10'h3FF);
    chk(10'(ctrlPinOe), 10'h007);
  endtask

  task tPortE;
    {portESel, portEDir, portEData, portEPullup} = 8'hEA;
    {portESelWr, portEPullupWr} = 2'h3;
    step(1);
    {portESelWr, portEPullupWr} = 2'h0;
    step(1);
    chk(10'(pinOe[1:0]), 10'h002);
    chk(10'(pinPullup[1:0]), 10'h000);
    extLvl[0] = 1'b1;
    step(3);
    chk(10'(portEIn), 10'h003);
    portEDir = 2'h1;
    portEData = 2'h0;
    step(4);
    chk(10'(pinOe[1:0]), 10'h001);
    chk(10'(portEIn), 10'h002);
  endtask

  task tPortA;
    {portASel, portADir, portAData, portAPullup} = 32'hFF55F0FE;
    {portASelWr, portAPullupWr} = 2'h3;
    step(1);
    {portASelWr, portAPullupWr} = 2'h0;
    step(1);
    chk(10'(pinOe[9:2]), 10'h055);
    chk(10'(pinOut[9:2] & 8'h55), 10'h050);
    chk(10'(pinPullup[9:2]), 10'h0AA);
    step(3);
    chk(10'(portAIn), 10'h0FA);
    portADir = 8'h54;
    step(2);
    chk(10'(pinPullup[9:2]), 10'h0AA);
  endtask

  initial begin
    {rstn, extBusActive, busDriveKeepWr, busDriveKeep} = 4'h0;
    {portESelWr, portEPullupWr, portASelWr, portAPullupWr} = 4'h0;
    {portESel, portEPullup, portEDir, portEData} = 8'h00;
    {portASel, portAPullup, portADir, portAData} = 32'h0;
    addrOut = 10'h2A5;
    ctrlOut = 3'h5;
    extLvl = 10'h000;
    tReset;
    tDrive;
    tPortE;
    tPortA;
    testDone;
  end

  initial begin
    repeat (500) @(posedge sys_clk);
    numErrors++;
    testDone;
  end
endmodule
